// ---- shared/rcu_map.vh ----
// Purpose: Constants for the range and signed compare unit
// Assumes: Included by bare name from design files
// Notes: Opcode codes are local encodings of the instruction select
`ifndef RCU_MAP_VH
`define RCU_MAP_VH
`define RCU_OP_SINGLE 2'h0
`define RCU_OP_DOUBLE 2'h1
`define RCU_OP_SIGNED 2'h2
`define RCU_OP_NONE 2'h3
`define RCU_WORD_W 16
`define RCU_FLAG_GREATER 3'h4
`define RCU_FLAG_EQUAL 3'h2
`define RCU_FLAG_LESS 3'h1
`define RCU_FLAG_NONE 3'h0
`endif

// ---- hw/rcu_cmp3.v ----
// Purpose: Three-way magnitude compare of two words
// Assumes: Combinational, signedness chosen by a port
// Notes: Used for all limit and signed checks
`timescale 1ns/10ps
`include "rcu_map.vh"
module rcu_cmp3 #(
  parameter W = 32
) (
  input wire [W-1:0] i_a,
  input wire [W-1:0] i_b,
  input wire i_signed,
  output wire o_lt,
  output wire o_eq,
  output wire o_gt
);
  wire [W-1:0] a_adj;
  wire [W-1:0] b_adj;
  // Flipping the sign bit turns a signed order into an unsigned one
  assign a_adj = {i_a[W-1] ^ i_signed, i_a[W-2:0]};
  assign b_adj = {i_b[W-1] ^ i_signed, i_b[W-2:0]};
  assign o_lt = a_adj < b_adj;
  assign o_eq = a_adj == b_adj;
  assign o_gt = a_adj > b_adj;
endmodule

// ---- hw/rcu_compare_unit.v ----
// Purpose: Range and signed compare execution unit
// Assumes: Operands already fetched; immediates arrive on the same ports
// Notes: Flags persist until the next executed compare
//   Range compares rank words as unsigned magnitudes
//   The error flag is rebuilt on every executed compare

`timescale 1ns/10ps
`include "rcu_map.vh"
module rcu_compare_unit #(
  parameter WORD_W = `RCU_WORD_W
) (
  input wire i_core_clk,
  input wire i_reset_n,
  input wire i_exec,
  input wire [1:0] i_opcode,
  input wire [WORD_W-1:0] i_compare_data_lo,
  input wire [WORD_W-1:0] i_compare_data_hi,
  input wire [WORD_W-1:0] i_lower_limit_lo,
  input wire [WORD_W-1:0] i_lower_limit_hi,
  input wire [WORD_W-1:0] i_upper_limit_lo,
  input wire [WORD_W-1:0] i_upper_limit_hi,
  input wire [WORD_W-1:0] i_first_operand,
  input wire [WORD_W-1:0] i_second_operand,
  input wire i_indirect_bad,
  output reg o_greater_flag,
  output reg o_equal_flag,
  output reg o_less_flag,
  output reg o_error_flag,
  output reg o_done
);
  // Double values are two words wide; single values are zero-extended
  localparam DW = 2 * WORD_W;
  wire is_double;
  reg [DW-1:0] cd_val;
  reg [DW-1:0] ll_val;
  reg [DW-1:0] ul_val;
  wire cd_lt_ll;
  wire cd_gt_ul;
  wire ll_gt_ul;
  wire s_lt;
  wire s_eq;
  wire s_gt;
  reg [2:0] res_next;
  reg err_next;
  reg hit;
  reg [2:0] range_res;
  reg range_err;
  reg [2:0] signed_res;
  reg signed_err;

  assign is_double = (i_opcode == `RCU_OP_DOUBLE);
  // Single form zero-extends the low word; the double form joins each
  // pair with the higher-addressed word as the upper half
  always @* begin
    if (is_double) begin
      cd_val = {i_compare_data_hi, i_compare_data_lo};
      ll_val = {i_lower_limit_hi, i_lower_limit_lo};
      ul_val = {i_upper_limit_hi, i_upper_limit_lo};
    end else begin
      // Unsigned magnitude: no sign extension of the low word
      cd_val = {{WORD_W{1'b0}}, i_compare_data_lo};
      ll_val = {{WORD_W{1'b0}}, i_lower_limit_lo};
      ul_val = {{WORD_W{1'b0}}, i_upper_limit_lo};
    end
  end

  // Compare data against the lower limit
  rcu_cmp3 #(.W(DW)) u_cd_ll (
    .i_a(cd_val),
    .i_b(ll_val),
    .i_signed(1'b0),
    .o_lt(cd_lt_ll),
    .o_eq(),
    .o_gt()
  );

  // Compare data against the upper limit
  rcu_cmp3 #(.W(DW)) u_cd_ul (
    .i_a(cd_val),
    .i_b(ul_val),
    .i_signed(1'b0),
    .o_lt(),
    .o_eq(),
    .o_gt(cd_gt_ul)
  );

  // Inverted range check feeds the error flag only
  rcu_cmp3 #(.W(DW)) u_ll_ul (
    .i_a(ll_val),
    .i_b(ul_val),
    .i_signed(1'b0),
    .o_lt(),
    .o_eq(),
    .o_gt(ll_gt_ul)
  );

  // Two's complement order of the two signed operands
  rcu_cmp3 #(.W(WORD_W)) u_signed (
    .i_a(i_first_operand),
    .i_b(i_second_operand),
    .i_signed(1'b1),
    .o_lt(s_lt),
    .o_eq(s_eq),
    .o_gt(s_gt)
  );

  // Range outcome; below lower is tested first, so an inverted range
  // still gives exactly one result flag alongside the error
  always @* begin
    range_res = `RCU_FLAG_EQUAL;
    if (cd_lt_ll) begin
      range_res = `RCU_FLAG_LESS;
    end else if (cd_gt_ul) begin
      range_res = `RCU_FLAG_GREATER;
    end
  end

  // Error is rebuilt on every executed range compare, never sticky
  always @* begin
    range_err = ll_gt_ul | i_indirect_bad;
  end

  // Signed outcome from the sign-flipped comparator
  always @* begin
    signed_res = `RCU_FLAG_NONE;
    if (s_lt) begin
      signed_res = `RCU_FLAG_LESS;
    end else if (s_gt) begin
      signed_res = `RCU_FLAG_GREATER;
    end else if (s_eq) begin
      signed_res = `RCU_FLAG_EQUAL;
    end
  end

  // A missing indirect word is the only signed error
  always @* begin
    signed_err = i_indirect_bad;
  end

  // Instruction select; opcode none or a low execution condition
  // leaves hit low, which freezes every flag register
  always @* begin
    res_next = `RCU_FLAG_NONE;
    err_next = 1'b0;
    hit = 1'b0;
    case (i_opcode)
      `RCU_OP_SINGLE: begin
        hit = i_exec;
        res_next = range_res;
        err_next = range_err;
      end
      `RCU_OP_DOUBLE: begin
        hit = i_exec;
        res_next = range_res;
        err_next = range_err;
      end
      `RCU_OP_SIGNED: begin
        hit = i_exec;
        res_next = signed_res;
        err_next = signed_err;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // One-cycle completion pulse per executed compare
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_done <= 1'b0;
    end else begin
      o_done <= hit;
    end
  end

  // Result flags hold when idle; the program must read them in time
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_greater_flag <= 1'b0;
      o_equal_flag <= 1'b0;
      o_less_flag <= 1'b0;
    end else if (hit) begin
      o_greater_flag <= res_next[2];
      o_equal_flag <= res_next[1];
      o_less_flag <= res_next[0];
    end
  end

  // Error flag follows the same execute gate as the result flags
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_error_flag <= 1'b0;
    end else if (hit) begin
      o_error_flag <= err_next;
    end
  end
endmodule

// ---- sim/rcu_cmp_asserts.sv ----
// Purpose: Flag checks
// Assumes: One clock
// Notes: Wide and signed results are judged by the bench
`timescale 1ns/10ps
module rcu_cmp_asserts(input wire i_core_clk, i_reset_n, i_exec,
  i_indirect_bad, o_greater_flag, o_equal_flag, o_less_flag, o_error_flag,
  o_done, input wire [1:0] i_opcode,
  input wire [15:0] i_compare_data_lo, i_lower_limit_lo, i_upper_limit_lo);
  wire [1:0] k = i_exec ? i_opcode : 2'h3;
  wire [3:0] f = {o_greater_flag, o_equal_flag, o_less_flag, o_error_flag};
  wire sl = i_compare_data_lo < i_lower_limit_lo;
  wire se = i_indirect_bad || i_lower_limit_lo > i_upper_limit_lo;
  sequence s_less;
    !k && sl ##1 &k;
  endsequence
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  chk_idle_hold: assert property (&k |=> $stable(f))
    else $error("idle flags moved");
  chk_idle_done: assert property (&k |=> !o_done)
    else $error("idle done");
  chk_one_flag: assert property (!(&k) |=> $onehot(f[3:1]))
    else $error("not one flag");
  chk_exec_done: assert property (!(&k) |=> o_done)
    else $error("no done");
  chk_sgl_less: assert property (!k |=> f[1] == $past(sl))
    else $error("less flag");
  chk_sgl_err: assert property (!k |=> f[0] == $past(se))
    else $error("error flag");
  chk_bad_addr: assert property (!(&k) && i_indirect_bad |=> f[0])
    else $error("indirect error");
  chk_less_kept: assert property (s_less |=> f[1])
    else $error("less lost");
endmodule
bind rcu_compare_unit rcu_cmp_asserts rcu_cmp_asserts_i (.*);

// ---- sim/rcu_seq_model.sv ----
// Purpose: Sequencer stand-in
// Assumes: One request per call
// Notes: Idle lines carry inverted data, never stale
`timescale 1ns/10ps
module rcu_seq_model(input wire i_core_clk, output reg [99:0] o_req);
  initial o_req = 100'h0;
  task issue(input [1:0] p, input [31:0] c, l, u, input b);
    begin
      @(posedge i_core_clk);
      #1 o_req = {1'b1, p, c, l, u, b};
      @(posedge i_core_clk);
      #1 o_req = {1'b0, ~o_req[98:0]};
    end
  endtask
  task issue_off(input [1:0] p, input [31:0] c, l, u, input b);
    begin
      @(posedge i_core_clk);
      #1 o_req = {1'b0, p, c, l, u, b};
      @(posedge i_core_clk);
      #1 o_req = {1'b0, ~o_req[98:0]};
    end
  endtask
endmodule

// ---- sim/rcu_compare_unit_tb.sv ----
// Purpose: Scenario bench
// Assumes: Model gives an idle cycle after each request
// Notes: Flags read right after the answering edge
`timescale 1ns/10ps
module rcu_compare_unit_tb;
  reg i_core_clk = 1'b0;
  reg i_reset_n = 1'b0;
  wire [99:0] q;
  wire [4:0] f;
  integer miscompares = 0;
  integer num_checks = 0;
  always #20 i_core_clk = ~i_core_clk;
  rcu_seq_model rcu_seq_model_i (.i_core_clk(i_core_clk), .o_req(q));
  rcu_compare_unit rcu_compare_unit_i (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_exec(q[99]), .i_opcode(q[98:97]),
    .i_compare_data_hi(q[96:81]), .i_compare_data_lo(q[80:65]),
    .i_lower_limit_hi(q[64:49]), .i_lower_limit_lo(q[48:33]),
    .i_upper_limit_hi(q[32:17]), .i_upper_limit_lo(q[16:1]),
    .i_first_operand(q[80:65]), .i_second_operand(q[48:33]),
    .i_indirect_bad(q[0]), .o_greater_flag(f[4]), .o_equal_flag(f[3]),
    .o_less_flag(f[2]), .o_error_flag(f[1]), .o_done(f[0]));
  task run(input [1:0] p, input [31:0] c, l, u, input b, input [4:0] x);
    begin
      rcu_seq_model_i.issue(p, c, l, u, b);
      num_checks = num_checks + 1;
      if (f !== x) begin
        miscompares = miscompares + 1;
        $display("[FAIL] flags exp %b got %b", x, f);
      end
    end
  endtask
  task run_off(input [1:0] p, input [31:0] c, l, u, input b,
    input [4:0] x);
    begin
      rcu_seq_model_i.issue_off(p, c, l, u, b);
      num_checks = num_checks + 1;
      if (f !== x) begin
        miscompares = miscompares + 1;
        $display("[FAIL] idle flags exp %b got %b", x, f);
      end
    end
  endtask
  task t_off;
    begin
      run_off(2'h0, 32'h5, 32'h1, 32'h9, 1'b0, 5'h06);
      run_off(2'h1, 32'h5, 32'h1, 32'h9, 1'b1, 5'h06);
      run_off(2'h2, 32'h7, 32'h7, 32'h0, 1'b1, 5'h06);
    end
  endtask
  task t_single;
    begin
      run(2'h0, 32'hffff0001, 32'h1, 32'h9, 1'b0, 5'h09);
      run(2'h0, 32'h8000, 32'h1, 32'h9, 1'b0, 5'h11);
      run(2'h0, 32'h5, 32'h9, 32'h1, 1'b0, 5'h07);
    end
  endtask
  task t_double;
    begin
      run(2'h1, 32'hffff, 32'h10000, 32'h20000, 1'b0, 5'h05);
      run(2'h1, 32'h0, 32'h20000, 32'h10000, 1'b1, 5'h07);
    end
  endtask
  task t_signed;
    begin
      run(2'h2, 32'hffff, 32'h1, 32'h0, 1'b0, 5'h05);
      run(2'h2, 32'h1, 32'h8000, 32'h0, 1'b0, 5'h11);
      run(2'h2, 32'h7, 32'h7, 32'h0, 1'b1, 5'h0b);
      run(2'h3, 32'h0, 32'h1, 32'h0, 1'b1, 5'h0a);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #4000;
    miscompares = miscompares + 1;
    summarize;
  end
  initial begin
    #61 i_reset_n = 1'b1;
    t_single;
    t_off;
    t_double;
    t_signed;
    summarize;
  end
endmodule
